// >>> rtl/wmove_pkg.sv
// Purpose: Shared constants and types for the word move write path
// Assumes: 64-bit integer registers, 32-bit words
// Notes: Target register sets live outside this block
package wmove_pkg;

    localparam int WORD_W = 32;
    localparam int DWORD_W = 64;
    localparam int FREG_IDX_W = 5;
    localparam int CP2_SEL_W = 16;
    localparam int ODD_BIT = 0;
    localparam int MIN_UPPER_RELEASE = 2;
    localparam int DEF_ARCH_RELEASE = 2;

    // ------------------------------------------------------------
    // Word lane masks and fill value
    // ------------------------------------------------------------
    typedef logic [1:0] half_mask_t;
    localparam half_mask_t MASK_NONE = 2'h0;
    localparam half_mask_t MASK_LOW = 2'h1;
    localparam half_mask_t MASK_HIGH = 2'h2;
    localparam half_mask_t MASK_BOTH = 2'h3;
    localparam logic [WORD_W-1:0] UPPER_FILL = 32'h0;

    // ------------------------------------------------------------
    // Operations, states, exceptions
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MV_FLOAT_LOW = 3'h0,
        MV_FLOAT_HIGH = 3'h1,
        MV_CP2_HIGH = 3'h2,
        MV_CP2_LOW = 3'h3,
        MV_UPPER_PROD = 3'h6,
        MV_BOTTOM_PROD = 3'h7
    } move_op_t;

    typedef enum logic {
        RES_READ = 1'h0,
        RES_UNREAD = 1'h1
    } result_state_t;

    typedef enum logic [1:0] {
        EXC_NONE = 2'h0,
        EXC_RESERVED = 2'h1,
        EXC_COP_UNUSABLE = 2'h3
    } exc_t;

    typedef logic [1:0] cop_num_t;
    localparam cop_num_t COP_NONE = 2'h0;
    localparam cop_num_t COP_FLOAT = 2'h1;
    localparam cop_num_t COP_CP2 = 2'h2;

endpackage

// >>> rtl/prod_if.sv
// Purpose: Carrier between move decode and product result registers
// Assumes: One clock domain
// Notes: Write strobes are one-cycle pulses
`timescale 1ns/1ps
interface prod_if;
    import wmove_pkg::*;
    logic wr_upper;
    logic wr_bottom;
    logic [DWORD_W-1:0] wdata;
    logic md_valid;
    logic [DWORD_W-1:0] md_upper;
    logic [DWORD_W-1:0] md_lower;
    logic rd;
    logic [DWORD_W-1:0] upper;
    logic [DWORD_W-1:0] bottom;
    logic misuse;

    modport owner (
        input wr_upper, wr_bottom, wdata, md_valid, md_upper, md_lower, rd,
        output upper, bottom, misuse
    );
    modport user (
        output wr_upper, wr_bottom, wdata, md_valid, md_upper, md_lower, rd,
        input upper, bottom, misuse
    );
endinterface

// >>> rtl/product_result_regs.sv
// Purpose: Upper and bottom multiply/divide result registers
// Assumes: Explicit write and unit result may meet in one cycle
// Notes: Explicit write wins over a unit result
`timescale 1ns/1ps
module product_result_regs (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Carrier
    prod_if.owner pr
);
    import wmove_pkg::*;

    typedef struct packed {
        logic [DWORD_W-1:0] upper;
        logic [DWORD_W-1:0] bottom;
        result_state_t state;
        logic misuse;
    } prod_state_t;

    prod_state_t s_r;
    prod_state_t s_nxt;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.misuse = 1'b0;
        if (pr.md_valid) begin
            s_nxt.upper = pr.md_upper;
            s_nxt.bottom = pr.md_lower;
        end
        // Unread result tracking, set wins over clear
        unique case (s_r.state)
            RES_READ: begin
                if (pr.md_valid) begin
                    s_nxt.state = RES_UNREAD;
                end
            end
            RES_UNREAD: begin
                if (pr.rd && !pr.md_valid) begin
                    s_nxt.state = RES_READ;
                end
            end
        endcase
        // Read needs no spacing before a write, see RULE_13
        if (pr.wr_upper) begin
            s_nxt.upper = pr.wdata; // see RULE_09
            if (s_r.state == RES_UNREAD && !pr.rd) begin
                s_nxt.misuse = 1'b1; // see RULE_11
            end
        end
        if (pr.wr_bottom) begin
            s_nxt.bottom = pr.wdata; // see RULE_10
            if (s_r.state == RES_UNREAD && !pr.rd) begin
                s_nxt.misuse = 1'b1; // see RULE_12
            end
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pr.upper = s_r.upper;
    assign pr.bottom = s_r.bottom;
    assign pr.misuse = s_r.misuse;

endmodule

// >>> rtl/word_move_to_target_regs.sv
// Purpose: Write path moving an integer register word to other sets
// Assumes: One move request per cycle, taken when move_valid is high
// Notes: Float and coprocessor 2 register files sit outside
//
// Behaviour
// RULE_01: Word-to-float move writes low word; upper half left undefined.
// RULE_02: Word-to-coproc2 move writes low word of selected register.
// RULE_03: Coproc2 selector is 16 bits, passed on uninterpreted.
// RULE_04: Float upper-half move writes bits 63..32, keeps low word.
// RULE_05: Software avoids float upper move to odd index with mode 0.
// RULE_06: Coproc2 upper-half move writes bits 63..32, keeps low word.
// RULE_07: Upper-half moves before release 2 raise reserved instruction.
// RULE_08: Software issues low-word move before upper-half move.
// RULE_09: Upper product write loads full integer register into upper.
// RULE_10: Bottom product write loads full integer register into bottom.
// RULE_11: Upper write before result read leaves bottom unpredictable.
// RULE_12: Bottom write before result read leaves upper unpredictable.
// RULE_13: No spacing needed between result read and later write.
// RULE_14: Disabled target coprocessor raises unusable exception, no write.
`timescale 1ns/1ps
module word_move_to_target_regs #(
    parameter int ARCH_RELEASE = wmove_pkg::DEF_ARCH_RELEASE
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Move request
    input wire logic move_valid,
    input wire wmove_pkg::move_op_t move_op,
    input wire logic [wmove_pkg::DWORD_W-1:0] integer_reg,
    input wire logic [wmove_pkg::FREG_IDX_W-1:0] float_idx,
    input wire logic [wmove_pkg::CP2_SEL_W-1:0] cp2_sel,
    // Coprocessor status
    input wire logic float_usable,
    input wire logic cp2_usable,
    input wire logic float_reg_mode_bit,
    // Multiply/divide unit
    input wire logic md_result_valid,
    input wire logic [wmove_pkg::DWORD_W-1:0] md_upper,
    input wire logic [wmove_pkg::DWORD_W-1:0] md_lower,
    input wire logic result_read,
    // Float register write port
    output logic float_we_r,
    output logic [wmove_pkg::FREG_IDX_W-1:0] float_widx_r,
    output logic [wmove_pkg::DWORD_W-1:0] float_wdata_r,
    output wmove_pkg::half_mask_t float_wmask_r,
    // Coprocessor 2 register write port
    output logic cp2_we_r,
    output logic [wmove_pkg::CP2_SEL_W-1:0] cp2_wsel_r,
    output logic [wmove_pkg::DWORD_W-1:0] cp2_wdata_r,
    output wmove_pkg::half_mask_t cp2_wmask_r,
    // Product result registers
    output logic [wmove_pkg::DWORD_W-1:0] upper_result_reg_r,
    output logic [wmove_pkg::DWORD_W-1:0] bottom_result_reg_r,
    // Exceptions and misuse
    output logic exc_valid_r,
    output wmove_pkg::exc_t exc_cause_r,
    output wmove_pkg::cop_num_t exc_cop_r,
    output logic misuse_r
);
    import wmove_pkg::*;

    typedef struct packed {
        logic f_we;
        logic [FREG_IDX_W-1:0] f_idx;
        logic [DWORD_W-1:0] f_data;
        half_mask_t f_mask;
        logic c_we;
        logic [CP2_SEL_W-1:0] c_sel;
        logic [DWORD_W-1:0] c_data;
        half_mask_t c_mask;
        logic exc_valid;
        exc_t exc_cause;
        cop_num_t exc_cop;
        logic misuse;
    } move_state_t;

    move_state_t s_r;
    move_state_t s_nxt;
    prod_if pr ();

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [DWORD_W-1:0] low_word(
        input logic [DWORD_W-1:0] v
    );
        return {UPPER_FILL, v[WORD_W-1:0]};
    endfunction

    function automatic logic [DWORD_W-1:0] high_word(
        input logic [DWORD_W-1:0] v
    );
        return {v[WORD_W-1:0], UPPER_FILL};
    endfunction

    localparam logic UPPER_OK = (ARCH_RELEASE >= MIN_UPPER_RELEASE);

    // ------------------------------------------------------------
    // Product result registers
    // ------------------------------------------------------------
    assign pr.wr_upper = move_valid && (move_op == MV_UPPER_PROD);
    assign pr.wr_bottom = move_valid && (move_op == MV_BOTTOM_PROD);
    assign pr.wdata = integer_reg;
    assign pr.md_valid = md_result_valid;
    assign pr.md_upper = md_upper;
    assign pr.md_lower = md_lower;
    assign pr.rd = result_read;

    product_result_regs u_prod (
        .clock(clock),
        .sys_rst(sys_rst),
        .pr(pr)
    );

    // ------------------------------------------------------------
    // Move decode
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.f_we = 1'b0;
        s_nxt.c_we = 1'b0;
        s_nxt.exc_valid = 1'b0;
        s_nxt.exc_cause = EXC_NONE;
        s_nxt.exc_cop = COP_NONE;
        s_nxt.misuse = pr.misuse;
        if (move_valid) begin
            unique case (move_op)
                MV_FLOAT_LOW: begin
                    if (!float_usable) begin
                        s_nxt.exc_valid = 1'b1; // see RULE_14
                        s_nxt.exc_cause = EXC_COP_UNUSABLE;
                        s_nxt.exc_cop = COP_FLOAT;
                    end else begin
                        s_nxt.f_we = 1'b1; // see RULE_01
                        s_nxt.f_idx = float_idx;
                        s_nxt.f_data = low_word(integer_reg);
                        s_nxt.f_mask = MASK_BOTH;
                    end
                end
                MV_FLOAT_HIGH: begin
                    if (!UPPER_OK) begin
                        s_nxt.exc_valid = 1'b1; // see RULE_07
                        s_nxt.exc_cause = EXC_RESERVED;
                    end else if (!float_usable) begin
                        s_nxt.exc_valid = 1'b1; // see RULE_14
                        s_nxt.exc_cause = EXC_COP_UNUSABLE;
                        s_nxt.exc_cop = COP_FLOAT;
                    end else begin
                        s_nxt.f_we = 1'b1; // see RULE_04
                        s_nxt.f_idx = float_idx;
                        s_nxt.f_data = high_word(integer_reg);
                        s_nxt.f_mask = MASK_HIGH;
                        if (!float_reg_mode_bit && float_idx[ODD_BIT]) begin
                            s_nxt.misuse = 1'b1; // see RULE_05
                        end
                    end
                end
                MV_CP2_LOW: begin
                    if (!cp2_usable) begin
                        s_nxt.exc_valid = 1'b1; // see RULE_14
                        s_nxt.exc_cause = EXC_COP_UNUSABLE;
                        s_nxt.exc_cop = COP_CP2;
                    end else begin
                        s_nxt.c_we = 1'b1; // see RULE_02
                        s_nxt.c_sel = cp2_sel; // see RULE_03
                        s_nxt.c_data = low_word(integer_reg);
                        s_nxt.c_mask = MASK_BOTH;
                    end
                end
                MV_CP2_HIGH: begin
                    if (!UPPER_OK) begin
                        s_nxt.exc_valid = 1'b1; // see RULE_07
                        s_nxt.exc_cause = EXC_RESERVED;
                    end else if (!cp2_usable) begin
                        s_nxt.exc_valid = 1'b1; // see RULE_14
                        s_nxt.exc_cause = EXC_COP_UNUSABLE;
                        s_nxt.exc_cop = COP_CP2;
                    end else begin
                        s_nxt.c_we = 1'b1; // see RULE_06
                        s_nxt.c_sel = cp2_sel; // see RULE_03
                        s_nxt.c_data = high_word(integer_reg);
                        s_nxt.c_mask = MASK_HIGH;
                    end
                end
                MV_UPPER_PROD, MV_BOTTOM_PROD: begin
                end
                default: begin
                    s_nxt.exc_valid = 1'b1;
                    s_nxt.exc_cause = EXC_RESERVED;
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign float_we_r = s_r.f_we;
    assign float_widx_r = s_r.f_idx;
    assign float_wdata_r = s_r.f_data;
    assign float_wmask_r = s_r.f_mask;
    assign cp2_we_r = s_r.c_we;
    assign cp2_wsel_r = s_r.c_sel;
    assign cp2_wdata_r = s_r.c_data;
    assign cp2_wmask_r = s_r.c_mask;
    assign upper_result_reg_r = pr.upper;
    assign bottom_result_reg_r = pr.bottom;
    assign exc_valid_r = s_r.exc_valid;
    assign exc_cause_r = s_r.exc_cause;
    assign exc_cop_r = s_r.exc_cop;
    assign misuse_r = s_r.misuse;

endmodule

// >>> sim/wmove_checker.sv
// Purpose: Concurrent checks on the word move write path
// Assumes: One clock, asynchronous active-high reset
// Notes: Bound to every instance of the top module
`timescale 1ns/1ps
module wmove_checker #(
    parameter int ARCH_RELEASE = wmove_pkg::DEF_ARCH_RELEASE
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Request
    input wire logic move_valid,
    input wire wmove_pkg::move_op_t move_op,
    input wire logic [wmove_pkg::DWORD_W-1:0] integer_reg,
    input wire logic [wmove_pkg::CP2_SEL_W-1:0] cp2_sel,
    input wire logic float_usable,
    input wire logic cp2_usable,
    // Results
    input wire logic float_we_r,
    input wire logic [wmove_pkg::DWORD_W-1:0] float_wdata_r,
    input wire wmove_pkg::half_mask_t float_wmask_r,
    input wire logic cp2_we_r,
    input wire logic [wmove_pkg::CP2_SEL_W-1:0] cp2_wsel_r,
    input wire logic [wmove_pkg::DWORD_W-1:0] cp2_wdata_r,
    input wire wmove_pkg::half_mask_t cp2_wmask_r,
    input wire logic [wmove_pkg::DWORD_W-1:0] upper_result_reg_r,
    input wire logic [wmove_pkg::DWORD_W-1:0] bottom_result_reg_r,
    input wire logic exc_valid_r,
    input wire wmove_pkg::exc_t exc_cause_r,
    input wire wmove_pkg::cop_num_t exc_cop_r,
    input wire logic misuse_r
);
    import wmove_pkg::*;
    // ------------
    // Checks
    // ------------
    default clocking @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    wire logic rel_ok = ARCH_RELEASE >= MIN_UPPER_RELEASE;
    wire logic [WORD_W-1:0] lw = integer_reg[WORD_W-1:0];
    float_low_a: assert property (
        move_valid && move_op == MV_FLOAT_LOW && float_usable |=>
        float_we_r && float_wmask_r == MASK_BOTH
        && float_wdata_r[31:0] == $past(lw))
        else $error("float low move wrong");
    float_high_a: assert property (
        move_valid && move_op == MV_FLOAT_HIGH && float_usable && rel_ok
        |=> float_we_r && float_wmask_r == MASK_HIGH
        && float_wdata_r[63:32] == $past(lw))
        else $error("float high move wrong");
    cp2_low_a: assert property (
        move_valid && move_op == MV_CP2_LOW && cp2_usable |=>
        cp2_we_r && cp2_wsel_r == $past(cp2_sel)
        && cp2_wdata_r[31:0] == $past(lw) && cp2_wmask_r == MASK_BOTH)
        else $error("cp2 low move wrong");
    cp2_high_a: assert property (
        move_valid && move_op == MV_CP2_HIGH && cp2_usable && rel_ok
        |=> cp2_we_r && cp2_wmask_r == MASK_HIGH
        && cp2_wdata_r[63:32] == $past(lw))
        else $error("cp2 high move wrong");
    upper_load_a: assert property (
        move_valid && move_op == MV_UPPER_PROD |-> ##1
        upper_result_reg_r == $past(integer_reg))
        else $error("upper product write lost");
    bottom_load_a: assert property (
        move_valid && move_op == MV_BOTTOM_PROD |=>
        bottom_result_reg_r == $past(integer_reg))
        else $error("bottom product write lost");
    cop_unusable_a: assert property (
        move_valid && (move_op == MV_FLOAT_LOW && !float_usable
        || move_op == MV_CP2_LOW && !cp2_usable) |=> exc_valid_r
        && exc_cause_r == EXC_COP_UNUSABLE && !float_we_r && !cp2_we_r
        && exc_cop_r == ($past(move_op) == MV_CP2_LOW ? COP_CP2 : COP_FLOAT))
        else $error("unusable coprocessor not trapped");
    reserved_a: assert property (
        move_valid && !rel_ok
        && (move_op == MV_FLOAT_HIGH || move_op == MV_CP2_HIGH) |=>
        exc_valid_r && exc_cause_r == EXC_RESERVED && !float_we_r
        && !cp2_we_r)
        else $error("early upper move not reserved");
    cover property (move_valid && move_op == MV_CP2_HIGH ##1 cp2_we_r);
    cover property (exc_valid_r && exc_cause_r == EXC_RESERVED);
    cover property (misuse_r);
endmodule

bind word_move_to_target_regs wmove_checker #(
    .ARCH_RELEASE(ARCH_RELEASE)
) wmove_checker_i (.clock, .sys_rst, .move_valid, .move_op, .integer_reg,
    .cp2_sel, .float_usable, .cp2_usable, .float_we_r, .float_wdata_r,
    .float_wmask_r, .cp2_we_r, .cp2_wsel_r, .cp2_wdata_r, .cp2_wmask_r,
    .upper_result_reg_r, .bottom_result_reg_r, .exc_valid_r,
    .exc_cause_r, .exc_cop_r, .misuse_r);

// >>> sim/target_regs_model.sv
// Purpose: Float and coprocessor 2 register files behind the write ports
// Assumes: Sixteen coprocessor 2 registers, low selector bits pick one
// Notes: A masked write keeps the untouched word
`timescale 1ns/1ps
module target_regs_model (
    // Clock
    input wire logic clock,
    // Write ports
    input wire logic float_we_r,
    input wire logic [wmove_pkg::FREG_IDX_W-1:0] float_widx_r,
    input wire logic [wmove_pkg::DWORD_W-1:0] float_wdata_r,
    input wire wmove_pkg::half_mask_t float_wmask_r,
    input wire logic cp2_we_r,
    input wire logic [wmove_pkg::CP2_SEL_W-1:0] cp2_wsel_r,
    input wire logic [wmove_pkg::DWORD_W-1:0] cp2_wdata_r,
    input wire wmove_pkg::half_mask_t cp2_wmask_r
);
    import wmove_pkg::*;
    logic [DWORD_W-1:0] freg [32];
    logic [DWORD_W-1:0] creg [16];
    function automatic logic [DWORD_W-1:0] merge(logic [DWORD_W-1:0] o,
        logic [DWORD_W-1:0] n, half_mask_t m);
        return {m[1] ? n[63:32] : o[63:32], m[0] ? n[31:0] : o[31:0]};
    endfunction
    // ------------
    // Lane writes
    // ------------
    always @(posedge clock) begin
        if (float_we_r)
            freg[float_widx_r] <= merge(freg[float_widx_r], float_wdata_r,
                float_wmask_r);
        if (cp2_we_r)
            creg[cp2_wsel_r[3:0]] <= merge(creg[cp2_wsel_r[3:0]],
                cp2_wdata_r, cp2_wmask_r);
    end
endmodule

// >>> sim/word_move_to_target_regs_tb.sv
// Purpose: Self-checking bench for the word move write path
// Assumes: Inputs change 2 ns after each rising clock edge
// Notes: A second instance acts as a pre-release-2 core
`timescale 1ns/1ps
module word_move_to_target_regs_tb;
    import wmove_pkg::*;
    logic clock = 1'h0;
    logic sys_rst = 1'h1;
    logic move_valid, float_usable, cp2_usable, float_reg_mode_bit;
    logic md_result_valid, result_read, old_exc;
    move_op_t move_op;
    logic [DWORD_W-1:0] integer_reg, md_upper, md_lower, d, e;
    logic [FREG_IDX_W-1:0] float_idx, float_widx_r;
    logic [CP2_SEL_W-1:0] cp2_sel, cp2_wsel_r;
    logic [DWORD_W-1:0] float_wdata_r, cp2_wdata_r;
    logic [DWORD_W-1:0] upper_result_reg_r, bottom_result_reg_r;
    logic float_we_r, cp2_we_r, exc_valid_r, misuse_r;
    half_mask_t float_wmask_r, cp2_wmask_r;
    exc_t exc_cause_r, old_cause;
    cop_num_t exc_cop_r;
    logic [31:0] seed = 32'h96245191;
    int n_fail = 0;
    int comparisons = 0;
    move_op_t ops [6] = '{MV_FLOAT_LOW, MV_FLOAT_HIGH, MV_CP2_LOW,
        MV_CP2_HIGH, MV_UPPER_PROD, MV_BOTTOM_PROD};

    word_move_to_target_regs word_move_to_target_regs_i (.*);
    word_move_to_target_regs #(.ARCH_RELEASE(1)) word_move_rel1_i (.*,
        .exc_valid_r(old_exc), .exc_cause_r(old_cause), .exc_cop_r(),
        .float_we_r(), .float_widx_r(), .float_wdata_r(),
        .float_wmask_r(), .cp2_we_r(), .cp2_wsel_r(), .cp2_wdata_r(),
        .cp2_wmask_r(), .upper_result_reg_r(), .bottom_result_reg_r(),
        .misuse_r());
    target_regs_model target_regs_model_i (.*);

    always #25 clock = ~clock;

    // ------------
    // Helpers
    // ------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [DWORD_W-1:0] exp_data(logic hi,
        logic [DWORD_W-1:0] v);
        return hi ? {v[31:0], UPPER_FILL} : {UPPER_FILL, v[31:0]};
    endfunction
    task automatic check(logic [DWORD_W-1:0] seen, logic [DWORD_W-1:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: saw %0h want %0h", $time, seen, exp);
        end
    endtask
    task automatic issue(move_op_t op, logic [DWORD_W-1:0] v, logic rd);
        move_valid = 1'h1;
        move_op = op;
        integer_reg = v;
        result_read = rd;
        @(posedge clock);
        #2;
    endtask
    task automatic idle();
        move_valid = 1'h0;
        result_read = 1'h0;
        @(posedge clock);
        #2;
    endtask
    task automatic check_move(move_op_t op, logic [DWORD_W-1:0] v);
        logic hi;
        logic fl;
        logic [DWORD_W-1:0] wd;
        half_mask_t wm;
        logic [CP2_SEL_W-1:0] ws;
        logic [CP2_SEL_W-1:0] xs;
        hi = op inside {MV_FLOAT_HIGH, MV_CP2_HIGH};
        fl = op inside {MV_FLOAT_LOW, MV_FLOAT_HIGH};
        wd = fl ? float_wdata_r : cp2_wdata_r;
        wm = fl ? float_wmask_r : cp2_wmask_r;
        ws = fl ? float_widx_r : cp2_wsel_r;
        xs = fl ? float_idx : cp2_sel;
        check(old_exc, hi);
        check(old_cause, hi ? EXC_RESERVED : EXC_NONE);
        if (op == MV_UPPER_PROD)
            check(upper_result_reg_r, v);
        else if (op == MV_BOTTOM_PROD)
            check(bottom_result_reg_r, v);
        else begin
            check({float_we_r, cp2_we_r}, fl ? 2'h2 : 2'h1);
            check(wd, exp_data(hi, v));
            check(wm, hi ? MASK_HIGH : MASK_BOTH);
            check(ws, xs);
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ------------
    // Sequence
    // ------------
    initial begin
        repeat (5000) @(posedge clock);
        n_fail++;
        finish_test();
    end
    initial begin
        move_op_t op;
        {move_valid, md_result_valid, result_read} = 3'h0;
        {float_usable, cp2_usable, float_reg_mode_bit} = 3'h7;
        {integer_reg, md_upper, md_lower, d, e} = '0;
        move_op = MV_FLOAT_LOW;
        {float_idx, cp2_sel} = '0;
        repeat (5) @(posedge clock);
        #2;
        sys_rst = 1'h0;
        for (int i = 0; i < 60; i++) begin
            op = ops[rnd() % 6];
            d = {rnd(), rnd()};
            float_idx = FREG_IDX_W'(rnd());
            cp2_sel = CP2_SEL_W'(rnd());
            issue(op, d, 1'h0);
            check_move(op, d);
        end
        $display("test random moves done");
        e = {rnd(), rnd()};
        for (int k = 0; k < 4; k++) begin
            issue(ops[k], k[0] ? e : d, 1'h0);
            check_move(ops[k], k[0] ? e : d);
        end
        idle();
        e = {e[31:0], d[31:0]};
        check(target_regs_model_i.freg[float_idx], e);
        check(target_regs_model_i.creg[cp2_sel[3:0]], e);
        $display("test paired halves done");
        {float_usable, cp2_usable} = 2'h0;
        issue(MV_FLOAT_LOW, d, 1'h0);
        check({exc_valid_r, exc_cause_r, exc_cop_r, float_we_r},
            {1'h1, EXC_COP_UNUSABLE, COP_FLOAT, 1'h0});
        issue(MV_CP2_LOW, d, 1'h0);
        check({exc_valid_r, exc_cause_r, exc_cop_r, cp2_we_r},
            {1'h1, EXC_COP_UNUSABLE, COP_CP2, 1'h0});
        issue(MV_CP2_HIGH, d, 1'h0);
        check({exc_valid_r, exc_cause_r, exc_cop_r, cp2_we_r},
            {1'h1, EXC_COP_UNUSABLE, COP_CP2, 1'h0});
        idle();
        {float_usable, cp2_usable} = 2'h3;
        issue(move_op_t'(3'h4), d, 1'h0);
        check(exc_valid_r, 1'h1);
        check(exc_cause_r, EXC_RESERVED);
        float_reg_mode_bit = 1'h0;
        float_idx = 5'h1;
        issue(MV_FLOAT_HIGH, d, 1'h0);
        check(misuse_r, 1'h1);
        float_reg_mode_bit = 1'h1;
        idle();
        $display("test unusable coprocessor done");
        for (int k = 0; k < 3; k++) begin
            md_result_valid = 1'h1;
            md_upper = {rnd(), rnd()};
            md_lower = {rnd(), rnd()};
            @(posedge clock);
            #2;
            md_result_valid = 1'h0;
            check(upper_result_reg_r, md_upper);
            check(bottom_result_reg_r, md_lower);
            d = {rnd(), rnd()};
            issue(k == 1 ? MV_BOTTOM_PROD : MV_UPPER_PROD, d, k == 2);
            idle();
            check(misuse_r, k < 2);
        end
        $display("test product hazards done");
        finish_test();
    end
endmodule
